// File: rtl/msio_defines.vh
// Constants for the motion synchronization unit: register map, reset
// values, field positions and timing figures.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef MSIO_DEFINES_VH
`define MSIO_DEFINES_VH
`define MSIO_CLK_MHZ        100
`define MSIO_US_CYCLES      (`MSIO_CLK_MHZ)
`define MSIO_TOL_US         25
`define MSIO_ADDR_W         6
// Register byte offsets.
`define MSIO_REG_CTRL       6'h00
`define MSIO_REG_IN_LEN     6'h04
`define MSIO_REG_IN_OFS     6'h08
`define MSIO_REG_IN_SPD     6'h0C
`define MSIO_REG_OUT_LEN    6'h10
`define MSIO_REG_OUT_PER    6'h14
`define MSIO_REG_STATUS     6'h18
`define MSIO_REG_POS        6'h1C
// Control register fields.
`define MSIO_C_IN_EN        0
`define MSIO_C_IN_LVL_INV   1
`define MSIO_C_IN_EDGE_INV  2
`define MSIO_C_OUT_EN       3
`define MSIO_C_ON_START     4
`define MSIO_C_ON_STOP      5
`define MSIO_C_ON_PERIOD    6
`define MSIO_C_LEN_DIST     7
`define MSIO_C_GPO_MODE     8
`define MSIO_C_GPO_LVL      9
`define MSIO_C_OUT_INV      10
`define MSIO_CTRL_W         11
`define MSIO_CTRL_RST       11'h000
// Status register fields.
`define MSIO_S_IN_ACT       0
`define MSIO_S_OUT_ACT      1
`define MSIO_S_BUSY         2
`define MSIO_S_SYNC_MOVE    3
`define MSIO_S_OUT_LVL      4
`endif

// File: rtl/msio_top.v
// Motion synchronization unit: filtered sync input that launches relative
// shifts, and a sync output driven by motion events or by software.
// Assumes the motion engine reports position, moving and host commands.
`timescale 1ns/10ps
`include "msio_defines.vh"

module msio_top #(
  parameter POS_W = 32,
  parameter LEN_W = 16
) (
  input  wire             CLOCK_I,
  input  wire             RST_I,
  input  wire             CE_I,
  input  wire             SYNC_IN_I,
  input  wire [POS_W-1:0] POSITION_I,
  input  wire             MOVING_I,
  input  wire             HOST_CMD_I,
  input  wire             SHIFT_ACK_I,
  output reg              SHIFT_REQ_O,
  output reg              SHIFT_ADD_O,
  output reg  [POS_W-1:0] SHIFT_OFS_O,
  output reg  [31:0]      SHIFT_SPD_O,
  output reg              SYNC_OUT_O,
  input  wire [5:0]       S_AXI_AWADDR_I,
  input  wire             S_AXI_AWVALID_I,
  output reg              S_AXI_AWREADY_O,
  input  wire [31:0]      S_AXI_WDATA_I,
  input  wire [3:0]       S_AXI_WSTRB_I,
  input  wire             S_AXI_WVALID_I,
  output reg              S_AXI_WREADY_O,
  output reg  [1:0]       S_AXI_BRESP_O,
  output reg              S_AXI_BVALID_O,
  input  wire             S_AXI_BREADY_I,
  input  wire [5:0]       S_AXI_ARADDR_I,
  input  wire             S_AXI_ARVALID_I,
  output reg              S_AXI_ARREADY_O,
  input  wire             S_AXI_RREADY_I,
  output reg  [31:0]      S_AXI_RDATA_O,
  output reg  [1:0]       S_AXI_RRESP_O,
  output reg              S_AXI_RVALID_O
);

  localparam [7:0] US_CNT = `MSIO_US_CYCLES - 1;

  // Byte-lane merge used for every writable register.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  reg [`MSIO_CTRL_W-1:0] ctrl_q;
  reg [31:0]             in_len_q;
  reg [31:0]             in_ofs_q;
  reg [31:0]             in_spd_q;
  reg [31:0]             out_len_q;
  reg [31:0]             out_per_q;
  reg [5:0]              waddr_q;
  reg                    have_aw_q;
  reg                    have_w_q;
  reg [31:0]             wdata_q;
  reg [3:0]              wstrb_q;

  // One microsecond tick from the system clock.
  reg [7:0] us_cnt_q;
  wire      us_tick = (us_cnt_q == US_CNT);
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      us_cnt_q <= 8'h00;
    end else if (CE_I) begin
      us_cnt_q <= us_tick ? 8'h00 : us_cnt_q + 8'h01;
    end
  end

  // Input qualification. The raw pin is inverted by the edge bit so the
  // filter always looks for a rising edge; the level bit only shapes the
  // reported status, so flipping it alone can never launch a shift.
  wire in_lvl   = SYNC_IN_I ^ ctrl_q[`MSIO_C_IN_EDGE_INV];
  wire in_stat  = SYNC_IN_I ^ ctrl_q[`MSIO_C_IN_LVL_INV];
  reg         in_prev_q;
  reg         in_done_q;
  reg         boot_q;
  reg  [31:0] in_us_q;
  wire        in_rise = in_lvl & ~in_prev_q;
  wire        filt0   = (in_len_q == 32'h0000_0000);
  reg         accept;
  always @* begin
    accept = 1'b0;
    if (filt0) begin
      accept = in_rise | (boot_q & in_lvl);
    end else if (in_lvl && !in_done_q && us_tick &&
                 (in_us_q + 32'h0000_0001 >= in_len_q)) begin
      accept = 1'b1;
    end
  end

  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      in_prev_q <= 1'b1;
      in_done_q <= 1'b0;
      in_us_q   <= 32'h0000_0000;
      boot_q    <= 1'b1;
    end else if (CE_I) begin
      boot_q    <= 1'b0;
      in_prev_q <= in_lvl;
      if (!in_lvl) begin
        in_us_q   <= 32'h0000_0000;
        in_done_q <= 1'b0;
      end else begin
        if (us_tick) begin
          in_us_q <= in_us_q + 32'h0000_0001;
        end
        if (accept) begin
          in_done_q <= 1'b1;
        end
      end
    end
  end

  // Shift launch towards the motion engine. Offset and speed are sampled
  // only on acceptance so writes during a movement leave it alone.
  reg sync_move_q;
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      SHIFT_REQ_O <= 1'b0;
      SHIFT_ADD_O <= 1'b0;
      SHIFT_OFS_O <= {POS_W{1'b0}};
      SHIFT_SPD_O <= 32'h0000_0000;
      sync_move_q <= 1'b0;
    end else if (CE_I) begin
      if (SHIFT_REQ_O && SHIFT_ACK_I) begin
        SHIFT_REQ_O <= 1'b0;
      end
      if (accept && ctrl_q[`MSIO_C_IN_EN]) begin
        SHIFT_REQ_O <= 1'b1;
        SHIFT_ADD_O <= sync_move_q & MOVING_I;
        SHIFT_OFS_O <= in_ofs_q[POS_W-1:0];
        SHIFT_SPD_O <= in_spd_q;
        sync_move_q <= 1'b1;
      end else if (HOST_CMD_I || (!MOVING_I && !SHIFT_REQ_O)) begin
        sync_move_q <= 1'b0;
      end
    end
  end

  // Output event sources.
  reg              mov_prev_q;
  reg  [POS_W-1:0] pos_prev_q;
  reg  [POS_W-1:0] quo_q;
  wire [POS_W-1:0] per = (out_per_q[POS_W-1:0] == {POS_W{1'b0}}) ?
                         {{(POS_W-1){1'b0}}, 1'b1} : out_per_q[POS_W-1:0];
  // Floor division keeps marks at multiples of the period around zero.
  wire signed [POS_W-1:0] sp   = POSITION_I;
  wire signed [POS_W-1:0] sper = per;
  wire signed [POS_W-1:0] tq   = sp / sper;
  wire signed [POS_W-1:0] tr   = sp % sper;
  wire [POS_W-1:0] quo = (tr < 0) ? tq - {{(POS_W-1){1'b0}}, 1'b1} : tq;
  wire ev_start  = MOVING_I & ~mov_prev_q;
  wire ev_stop   = ~MOVING_I & mov_prev_q;
  wire at_zero   = (POSITION_I == {POS_W{1'b0}}) &&
                   (pos_prev_q != {POS_W{1'b0}});
  wire ev_period = (quo != quo_q) | at_zero;
  wire fire = (ctrl_q[`MSIO_C_ON_START]  & ev_start) |
              (ctrl_q[`MSIO_C_ON_STOP]   & ev_stop)  |
              (ctrl_q[`MSIO_C_ON_PERIOD] & ev_period);

  // Pulse stretcher. A new event restarts the remaining length, so
  // overlapping pulses merge. In distance mode the count drops per unit
  // moved, so a stop pulse holds until the next movement travels.
  reg  [31:0]      remain_q;
  reg              out_act_q;
  wire [POS_W-1:0] step_d = POSITION_I - pos_prev_q;
  wire [POS_W-1:0] step   = step_d[POS_W-1] ? (~step_d + 1'b1) : step_d;
  wire [31:0]      step32 = step;
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      mov_prev_q <= 1'b0;
      pos_prev_q <= {POS_W{1'b0}};
      quo_q      <= {POS_W{1'b0}};
      remain_q   <= 32'h0000_0000;
      out_act_q  <= 1'b0;
      SYNC_OUT_O <= 1'b0;
    end else if (CE_I) begin
      mov_prev_q <= MOVING_I;
      pos_prev_q <= POSITION_I;
      quo_q      <= quo;
      if (fire && ctrl_q[`MSIO_C_OUT_EN]) begin
        remain_q  <= out_len_q;
        out_act_q <= (out_len_q != 32'h0000_0000);
      end else if (ctrl_q[`MSIO_C_LEN_DIST]) begin
        if (remain_q <= step32) begin
          remain_q  <= 32'h0000_0000;
          out_act_q <= 1'b0;
        end else begin
          remain_q <= remain_q - step32;
        end
      end else if (us_tick) begin
        if (remain_q <= 32'h0000_0001) begin
          remain_q  <= 32'h0000_0000;
          out_act_q <= 1'b0;
        end else begin
          remain_q <= remain_q - 32'h0000_0001;
        end
      end
      if (ctrl_q[`MSIO_C_GPO_MODE]) begin
        SYNC_OUT_O <= ctrl_q[`MSIO_C_GPO_LVL];
      end else begin
        SYNC_OUT_O <= out_act_q ^ ctrl_q[`MSIO_C_OUT_INV];
      end
    end
  end

  // AXI4-Lite write path: address and data taken in either order.
  wire [31:0] w_d    = have_w_q ? wdata_q : S_AXI_WDATA_I;
  wire [3:0]  w_s    = have_w_q ? wstrb_q : S_AXI_WSTRB_I;
  wire [31:0] ctrl32 = {{(32-`MSIO_CTRL_W){1'b0}}, ctrl_q};
  wire [31:0] ctrl_n = merge(ctrl32, w_d, w_s);
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q          <= `MSIO_CTRL_RST;
      in_len_q        <= 32'h0000_0000;
      in_ofs_q        <= 32'h0000_0000;
      in_spd_q        <= 32'h0000_0000;
      out_len_q       <= 32'h0000_0000;
      out_per_q       <= 32'h0000_0000;
      waddr_q         <= 6'h00;
      wdata_q         <= 32'h0000_0000;
      wstrb_q         <= 4'h0;
      have_aw_q       <= 1'b0;
      have_w_q        <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= 2'b00;
    end else if (CE_I) begin
      S_AXI_AWREADY_O <= ~have_aw_q & ~S_AXI_AWREADY_O & ~S_AXI_BVALID_O;
      S_AXI_WREADY_O  <= ~have_w_q & ~S_AXI_WREADY_O & ~S_AXI_BVALID_O;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        have_aw_q <= 1'b1;
        waddr_q   <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        have_w_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA_I;
        wstrb_q  <= S_AXI_WSTRB_I;
      end
      if (have_aw_q && have_w_q && !S_AXI_BVALID_O) begin
        have_aw_q      <= 1'b0;
        have_w_q       <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= 2'b00;
        case (waddr_q)
          `MSIO_REG_CTRL:    ctrl_q    <= ctrl_n[`MSIO_CTRL_W-1:0];
          `MSIO_REG_IN_LEN:  in_len_q  <= merge(in_len_q, wdata_q, wstrb_q);
          `MSIO_REG_IN_OFS:  in_ofs_q  <= merge(in_ofs_q, wdata_q, wstrb_q);
          `MSIO_REG_IN_SPD:  in_spd_q  <= merge(in_spd_q, wdata_q, wstrb_q);
          `MSIO_REG_OUT_LEN: out_len_q <= merge(out_len_q, wdata_q, wstrb_q);
          `MSIO_REG_OUT_PER: out_per_q <= merge(out_per_q, wdata_q, wstrb_q);
          `MSIO_REG_STATUS,
          `MSIO_REG_POS:     S_AXI_BRESP_O <= 2'b00;
          default:           S_AXI_BRESP_O <= 2'b10;
        endcase
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path; one read at a time, unmapped reads give SLVERR.
  wire [31:0] status = {27'h0, SYNC_OUT_O, sync_move_q, MOVING_I,
                        out_act_q, in_stat};
  wire [31:0] pos32  = POSITION_I;
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= 2'b00;
    end else if (CE_I) begin
      S_AXI_ARREADY_O <= ~S_AXI_ARREADY_O & ~S_AXI_RVALID_O &
                         S_AXI_ARVALID_I;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O  <= 2'b00;
        case (S_AXI_ARADDR_I)
          `MSIO_REG_CTRL:    S_AXI_RDATA_O <= ctrl32;
          `MSIO_REG_IN_LEN:  S_AXI_RDATA_O <= in_len_q;
          `MSIO_REG_IN_OFS:  S_AXI_RDATA_O <= in_ofs_q;
          `MSIO_REG_IN_SPD:  S_AXI_RDATA_O <= in_spd_q;
          `MSIO_REG_OUT_LEN: S_AXI_RDATA_O <= out_len_q;
          `MSIO_REG_OUT_PER: S_AXI_RDATA_O <= out_per_q;
          `MSIO_REG_STATUS:  S_AXI_RDATA_O <= status;
          `MSIO_REG_POS:     S_AXI_RDATA_O <= pos32;
          default: begin
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= 2'b10;
          end
        endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

endmodule // msio_top

// File: tb/msio_properties.sv
// Concurrent checks on the ports of the sync unit top.
// Assumes the bench leaves edge inversion at its default.
`timescale 1ns/10ps
module msio_properties #(
  parameter POS_W = 32,
  parameter LEN_W = 16
) (
  input wire             CLOCK_I,
  input wire             RST_I,
  input wire             SYNC_IN_I,
  input wire             SHIFT_ACK_I,
  input wire             SHIFT_REQ_O,
  input wire [POS_W-1:0] SHIFT_OFS_O,
  input wire [31:0]      SHIFT_SPD_O,
  input wire             S_AXI_WVALID_I,
  input wire             S_AXI_WREADY_O,
  input wire             S_AXI_BVALID_O,
  input wire [1:0]       S_AXI_BRESP_O,
  input wire             S_AXI_BREADY_I,
  input wire             S_AXI_ARVALID_I,
  input wire             S_AXI_ARREADY_O,
  input wire             S_AXI_RVALID_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // A quiet pin may not produce a shift; a pending shift waits for ack.
  sequence s_quiet; (!SYNC_IN_I && !SHIFT_REQ_O)[*6]; endsequence
  sequence s_wait; SHIFT_REQ_O && !SHIFT_ACK_I; endsequence
  req_hold_a: assert property (s_wait |=> SHIFT_REQ_O)
    else $error("shift request dropped before ack");
  req_args_a: assert property (s_wait |=> $stable(SHIFT_OFS_O)
    && $stable(SHIFT_SPD_O)) else $error("shift values moved while pending");
  quiet_pin_a: assert property (s_quiet |=> !SHIFT_REQ_O)
    else $error("shift without input activity");
  req_cause_a: assert property ($rose(SHIFT_REQ_O) |-> $past(SYNC_IN_I)
    || $past(SYNC_IN_I, 2) || $past(SYNC_IN_I, 3))
    else $error("shift not caused by the input");
  b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("bvalid unstable");
  w_answer_a: assert property (S_AXI_WVALID_I && S_AXI_WREADY_O |->
    ##[1:4] S_AXI_BVALID_O) else $error("write not answered");
  r_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |->
    ##[1:4] S_AXI_RVALID_O) else $error("read not answered");
  ar_ready_a: assert property (S_AXI_ARVALID_I |-> ##[0:4] S_AXI_ARREADY_O)
    else $error("read address never taken");
endmodule // msio_properties

// File: tb/msio_sync_peer.sv
// Far-side instrument: drives sync pulses and times the sync output.
// Assumes an idle-low line, pulled down between pulses.
`timescale 1ns/10ps
module msio_sync_peer (
  input  wire  clk_i,
  input  wire  out_i,
  output logic sync_o
);
  int   width = 0;
  int   edges = 0;
  int   run   = 0;
  logic last  = 1'b0;
  initial sync_o = 1'b0;
  // Active high for n cycles, then back to the pulled-down idle level.
  task pulse(input int n);
    @(posedge clk_i);
    sync_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    sync_o <= 1'b0;
  endtask
  // Count starts of output pulses and keep the length of the last one.
  always @(posedge clk_i) begin
    last <= out_i;
    if (out_i && !last) edges <= edges + 1;
    if (out_i) run <= run + 1;
    else if (last) begin
      width <= run;
      run <= 0;
    end
  end
endmodule // msio_sync_peer

// File: tb/msio_top_test.sv
// Self-checking bench for the sync unit, with an AXI4-Lite master.
// Assumes the near-side motion engine is modelled here.
`timescale 1ns/10ps
module msio_top_test;
  logic clk = 0, rst = 1, moving = 0, host = 0, ack = 0, rq_q = 0, rv_q = 0;
  logic [31:0] pos = 0, wdata = 0;
  logic [5:0]  awaddr = 0, araddr = 0;
  logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, ce = 1;
  logic [3:0]  strb = 4'hF;
  wire         sync_in, req, add, sout, awr, wrd, bv, arr, rv;
  wire  [31:0] ofs, spd, rdata;
  wire  [1:0]  bresp, rresp;
  int          error_cnt = 0, total_checks = 0, e0, p, k;
  logic [64:0] sq[$];
  logic [33:0] rq[$];
  msio_top #(.POS_W(32), .LEN_W(16)) msio_top_inst (
    .CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .SYNC_IN_I(sync_in),
    .POSITION_I(pos), .MOVING_I(moving), .HOST_CMD_I(host),
    .SHIFT_ACK_I(ack), .SHIFT_REQ_O(req), .SHIFT_ADD_O(add),
    .SHIFT_OFS_O(ofs), .SHIFT_SPD_O(spd), .SYNC_OUT_O(sout),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
    .S_AXI_RREADY_I(rready),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv));
  msio_sync_peer msio_sync_peer_inst (.clk_i(clk), .out_i(sout),
    .sync_o(sync_in));
  initial forever #5 clk = ~clk;
  task chk(input string nm, input logic [64:0] s, input logic [64:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Both write channels offered together; bready held until bvalid.
  task wr(input [5:0] a, input [31:0] d, input [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!(bv && !awv && !wv) && n < 99);
    bready <= 0;
    chk("bresp", (n < 99) ? bresp : 2'bXX, er);
  endtask
  // The answer code is noted first and judged by the monitor.
  task rd(input [5:0] a, input [1:0] er, input [31:0] ed);
    int n;
    n = 0;
    rq.push_back({er, ed});
    @(posedge clk);
    araddr <= a; arv <= 1; rready <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 0;
    end while (!(rv && !arv) && n < 99);
    rready <= 0;
    if (n >= 99) chk("rd_timeout", 1, 0);
  endtask
  // Engine acks each request; new requests and answers meet their notes.
  always @(posedge clk) begin
    rq_q <= req;
    rv_q <= rv;
    ack <= req && !ack;
    // The engine starts moving once it sees a shift request.
    if (req) moving <= 1;
    if (req && !rq_q) begin
      if (sq.size() == 0) chk("unexpected_shift", 1, 0);
      else chk("shift", {add, ofs, spd}, sq.pop_front());
    end
    if (rv && !rv_q) chk("rd_answer", {rresp, rdata}, rq.pop_front());
  end
  // Input path first, then the output modes, then the register bus.
  initial begin
    void'($urandom(24414));
    repeat (8) @(posedge clk);
    rst <= 0;
    wr(6'h04, 32'h3, 2'h0);
    wr(6'h08, 32'h64, 2'h0);
    wr(6'h0C, 32'h7, 2'h0);
    wr(6'h00, 32'h1, 2'h0);
    msio_sync_peer_inst.pulse(150);
    sq.push_back({1'b0, 32'h64, 32'h7});
    msio_sync_peer_inst.pulse(400);
    moving <= 1;
    wr(6'h08, 32'hC8, 2'h0);
    sq.push_back({1'b1, 32'hC8, 32'h7});
    msio_sync_peer_inst.pulse(400);
    @(posedge clk) host <= 1;
    @(posedge clk) host <= 0;
    sq.push_back({1'b0, 32'hC8, 32'h7});
    msio_sync_peer_inst.pulse(400);
    moving <= 0;
    wr(6'h00, 32'h3, 2'h0);
    wr(6'h04, 32'h0, 2'h0);
    sq.push_back({1'b0, 32'hC8, 32'h7});
    msio_sync_peer_inst.pulse(3);
    wr(6'h00, 32'h0, 2'h0);
    msio_sync_peer_inst.pulse(400);
    wr(6'h00, 32'h308, 2'h0);
    repeat (4) @(posedge clk);
    chk("gpo_level", sout, 1);
    wr(6'h00, 32'h408, 2'h0);
    repeat (4) @(posedge clk);
    chk("out_polarity", sout, 1);
    moving <= 0;
    wr(6'h10, 32'h1E, 2'h0);
    wr(6'h00, 32'h18, 2'h0);
    moving <= 1;
    repeat (6000) @(posedge clk);
    moving <= 0;
    e0 = msio_sync_peer_inst.width;
    chk("time_pulse", e0 >= 500 && e0 <= 5500, 1);
    p = -1500;
    pos <= p;
    wr(6'h14, 32'h3E8, 2'h0);
    wr(6'h10, 32'h64, 2'h0);
    wr(6'h00, 32'hC8, 2'h0);
    for (k = 0; k < 2; k++) begin
      e0 = msio_sync_peer_inst.edges;
      while (k ? p > -1500 : p < 1500) begin
        @(posedge clk);
        p = k ? p - 1 - $urandom % 8 : p + 1 + $urandom % 8;
        pos <= p;
      end
      repeat (10) @(posedge clk);
      chk("marks", msio_sync_peer_inst.edges - e0, 3);
    end
    ce <= 0;
    pos <= 0;
    repeat (20) @(posedge clk);
    chk("ce_freeze", sout, 0);
    ce <= 1;
    repeat (4) @(posedge clk);
    chk("ce_run", sout, 1);
    strb <= 4'h1;
    wr(6'h08, 32'hFFFF_FF11, 2'h0);
    strb <= 4'hF;
    rd(6'h08, 2'h0, 32'h11);
    wr(6'h20, 32'h0, 2'h2);
    rd(6'h24, 2'h2, 32'h0);
    repeat (10) @(posedge clk);
    chk("notes_left", sq.size(), 0);
    results();
  end
endmodule // msio_top_test
bind msio_top msio_properties #(.POS_W(POS_W), .LEN_W(LEN_W))
  msio_properties_inst (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .SYNC_IN_I(SYNC_IN_I), .SHIFT_ACK_I(SHIFT_ACK_I),
  .SHIFT_REQ_O(SHIFT_REQ_O), .SHIFT_OFS_O(SHIFT_OFS_O),
  .SHIFT_SPD_O(SHIFT_SPD_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O));
